// ### rtl/psc_module_end.sv
// psc_module_end: sideband logic inside the pluggable module.
// assumes the host provides pull-ups on presence and interrupt lines and
// that the 2-wire engine outside uses mgmt_enable_o to gate its responses.
//
// Overview of operation
// (RULE1) selected low: answer management commands
// (RULE2) select high: ignore all management traffic
// (RULE3) select pin pulled up inside module
// (RULE4) reset pin pulled up inside module
// (RULE5) long reset low: restore all defaults
// (RULE6) init timing starts at reset release
// (RULE7) host ignores status during reset init
// (RULE8) completion: interrupt asserted, not-ready negated
// (RULE9) power-up posts the completion interrupt too
// (RULE10) low power input reduces module power
// (RULE11) presence tied low, host pulls up
// (RULE12) interrupt low flags fault or status
// (RULE13) host reads flags after interrupt
// (RULE14) interrupt only sinks, host pulls up
// (RULE15) short reset pulses ignored; not-ready during init
`timescale 1ns/100ps
module psc_module_end
  import psc_pkg::*;
#(
  parameter int unsigned RESET_MIN_CYC = RESET_PULSE_MIN_CYC,
  parameter int unsigned INIT_CYC      = RESET_INIT_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // sideband pins
  psc_if.dev              pins,
  // user side: management gating and status
  output logic            mgmt_enable_o,
  output logic            data_not_ready_o,
  output logic            low_power_o,
  output logic [7:0]      user_cfg_o,
  input  wire logic       user_cfg_we_i,
  input  wire logic [7:0] user_cfg_i,
  input  wire logic       fault_i,
  input  wire logic       flags_read_i
);
  localparam int unsigned IW = $clog2(INIT_CYC + 1);

  psc_dev_state_t state_q;
  logic [IW-1:0]  init_cnt_q;
  logic           long_low;
  logic           int_pend_q;
  logic           init_done;

  psc_pulse_filter #(
    .MIN_CYC (RESET_MIN_CYC)
  ) u_rst_filter (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .level_n_i  (pins.module_reset_n),
    .long_low_o (long_low)
  );

  assign init_done = (state_q == PSC_INIT) && (init_cnt_q == IW'(INIT_CYC - 1));

  // power-up starts in init so the completion interrupt posts unprompted, see RULE9
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= PSC_INIT;
    end else begin
      unique case (state_q)
        PSC_RUN:  if (long_low) state_q <= PSC_HELD; // see RULE15
        PSC_HELD: if (pins.module_reset_n) state_q <= PSC_INIT; // see RULE6
        PSC_INIT: begin
          if (long_low) begin
            state_q <= PSC_HELD;
          end else if (init_done) begin
            state_q <= PSC_RUN;
          end
        end
      endcase
    end
  end

  // init counter runs only from the release edge onward, see RULE6
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_cnt_q <= '0;
    end else if (state_q != PSC_INIT) begin
      init_cnt_q <= '0;
    end else if (!init_done) begin
      init_cnt_q <= init_cnt_q + IW'(1);
    end
  end

  // not-ready stays high throughout hold and init, see RULE15
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_not_ready_o <= 1'b1;
    end else if (long_low || state_q == PSC_HELD) begin
      data_not_ready_o <= 1'b1;
    end else if (init_done) begin
      data_not_ready_o <= 1'b0; // see RULE8
    end
  end

  // settings return to defaults on a qualified reset, see RULE5
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      user_cfg_o <= USER_CFG_RESET;
    end else if (state_q == PSC_HELD || long_low) begin
      user_cfg_o <= USER_CFG_RESET;
    end else if (user_cfg_we_i && mgmt_enable_o) begin
      user_cfg_o <= user_cfg_i;
    end
  end

  // completion and fault events latch the interrupt; a new event beats the
  // clear by the flag read, so nothing is lost
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_pend_q <= 1'b0;
    end else if (init_done || (fault_i && state_q == PSC_RUN)) begin
      int_pend_q <= 1'b1; // see RULE8, see RULE12
    end else if (flags_read_i || state_q == PSC_HELD) begin
      int_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_power_o <= 1'b0;
    end else begin
      low_power_o <= pins.low_power_request; // see RULE10
    end
  end

  // management only answers while selected and out of hold
  assign mgmt_enable_o = !pins.module_select_n && (state_q != PSC_HELD); // see RULE1, see RULE2

  // line is only ever sunk, never driven high, see RULE14
  assign pins.int_oe_dev     = int_pend_q; // see RULE12
  assign pins.present_oe_dev = 1'b1;       // see RULE11
endmodule

// ### rtl/psc_pkg.sv
// psc_pkg: shared constants and types of the pluggable module sideband block.
// assumes a 20 MHz clock on both ends.
package psc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;

  // least low time on the reset pin that counts as a reset, in ns
  localparam int unsigned RESET_PULSE_MIN_NS = 10_000;
  localparam int unsigned RESET_PULSE_MIN_CYC =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset execution interval after release, in us
  localparam int unsigned RESET_INIT_US = 2_000;
  localparam int unsigned RESET_INIT_CYC = (RESET_INIT_US * 1000) / CLK_PERIOD_NS;

  // host side: how long the reset pin is held low
  localparam int unsigned HOST_RESET_HOLD_CYC = RESET_PULSE_MIN_CYC + 2;

  // reset values of the module user settings
  localparam logic [7:0] USER_CFG_RESET = 8'h00;

  typedef enum logic [1:0] {
    PSC_RUN,
    PSC_HELD,
    PSC_INIT
  } psc_dev_state_t;

  typedef enum logic [1:0] {
    PSC_H_IDLE,
    PSC_H_RESET,
    PSC_H_WAIT
  } psc_host_state_t;

endpackage

// ### rtl/psc_if.sv
// psc_if: sideband pins between host and pluggable module.
// open-collector and pulled lines are resolved here from the enables.
`timescale 1ns/100ps
interface psc_if;
  // host driven select, reset and low power
  logic sel_n_o_host;
  logic sel_n_oe_host;
  logic rst_n_o_host;
  logic rst_n_oe_host;
  logic lp_o_host;
  // module driven presence tie and interrupt sink
  logic present_oe_dev;
  logic int_oe_dev;
  // resolved line levels
  logic module_select_n;
  logic module_reset_n;
  logic low_power_request;
  logic module_present_n;
  logic module_interrupt_n;

  // module pull-ups keep select and reset high when undriven
  assign module_select_n    = sel_n_oe_host ? sel_n_o_host : 1'b1; // see RULE3
  assign module_reset_n     = rst_n_oe_host ? rst_n_o_host : 1'b1; // see RULE4
  assign low_power_request  = lp_o_host;
  // host pull-ups; the module only ever pulls low
  assign module_present_n   = present_oe_dev ? 1'b0 : 1'b1;
  assign module_interrupt_n = int_oe_dev ? 1'b0 : 1'b1; // see RULE14

  modport dev (
    input  module_select_n,
    input  module_reset_n,
    input  low_power_request,
    output present_oe_dev,
    output int_oe_dev
  );

  modport host (
    output sel_n_o_host,
    output sel_n_oe_host,
    output rst_n_o_host,
    output rst_n_oe_host,
    output lp_o_host,
    input  module_present_n,
    input  module_interrupt_n
  );
endinterface

// ### rtl/psc_pulse_filter.sv
// psc_pulse_filter: qualifies a low level that lasts at least MIN_CYC cycles.
// assumes the input is synchronous to clk_i.
`timescale 1ns/100ps
module psc_pulse_filter #(
  parameter int unsigned MIN_CYC = 200
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // level in, qualified flag out
  input  wire logic level_n_i,
  output logic      long_low_o
);
  localparam int unsigned CW = $clog2(MIN_CYC + 1);
  logic [CW-1:0] cnt_q;

  // saturating count of low cycles; any high level restarts it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (level_n_i) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(MIN_CYC)) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign long_low_o = (cnt_q == CW'(MIN_CYC));
endmodule

// ### rtl/psc_host_end.sv
// psc_host_end: host board controller for one pluggable module.
// assumes the interface supplies pull-ups; management reads are outside.
`timescale 1ns/100ps
module psc_host_end
  import psc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = HOST_RESET_HOLD_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // sideband pins
  psc_if.host       pins,
  // user side
  input  wire logic reset_req_i,
  input  wire logic select_i,
  input  wire logic low_power_i,
  output logic      present_o,
  output logic      status_valid_o,
  output logic      read_flags_o,
  output logic      busy_o
);
  localparam int unsigned HW = $clog2(HOLD_CYC + 1);

  psc_host_state_t state_q;
  logic [HW-1:0]   cnt_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= PSC_H_WAIT;
    end else begin
      unique case (state_q)
        PSC_H_IDLE:  if (reset_req_i) state_q <= PSC_H_RESET;
        PSC_H_RESET: if (cnt_q == HW'(HOLD_CYC - 1)) state_q <= PSC_H_WAIT;
        // status is distrusted until the completion interrupt, see RULE7
        PSC_H_WAIT:  if (!pins.module_interrupt_n) state_q <= PSC_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (state_q == PSC_H_RESET) begin
      cnt_q <= cnt_q + HW'(1);
    end else begin
      cnt_q <= '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      present_o    <= 1'b0;
      read_flags_o <= 1'b0;
    end else begin
      present_o    <= !pins.module_present_n; // see RULE11
      // interrupt low prompts a flag read over management, see RULE13
      read_flags_o <= !pins.module_interrupt_n && state_q != PSC_H_RESET;
    end
  end

  assign status_valid_o     = (state_q == PSC_H_IDLE);
  assign busy_o             = (state_q != PSC_H_IDLE);
  assign pins.rst_n_o_host  = (state_q != PSC_H_RESET);
  assign pins.rst_n_oe_host = 1'b1;
  assign pins.sel_n_o_host  = !select_i;
  assign pins.sel_n_oe_host = 1'b1;
  assign pins.lp_o_host     = low_power_i; // see RULE10
endmodule

// ### verif/psc_sva.sv
// psc_sva: checks on the sideband pins between host and module ends.
// assumes one clock domain and that it sits beside the joining interface.
`timescale 1ns/100ps
module psc_sva #(
  parameter int unsigned MIN_CYC  = 4,
  parameter int unsigned INIT_CYC = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // interface signals
  input wire logic sel_n_oe_host,
  input wire logic rst_n_oe_host,
  input wire logic present_oe_dev,
  input wire logic int_oe_dev,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic module_present_n,
  input wire logic module_interrupt_n
);
  localparam int LO = INIT_CYC - 2;
  localparam int HI = INIT_CYC + 4;
  logic [15:0] low_q;
  logic [15:0] cyc_q;
  logic        done_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_q <= '0;
    end else if (module_reset_n) begin
      low_q <= '0;
    end else if (low_q != 16'hffff) begin
      low_q <= low_q + 16'h0001;
    end
  end

  // timing restarts only on release of a qualified reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_q  <= '0;
      done_q <= 1'b0;
    end else if (module_reset_n && low_q > 16'(MIN_CYC)) begin
      cyc_q  <= '0;
      done_q <= 1'b0;
    end else begin
      if (cyc_q != 16'hffff) begin
        cyc_q <= cyc_q + 16'h0001;
      end
      if (!module_interrupt_n) begin
        done_q <= 1'b1;
      end
    end
  end

  sequence qual_low_s;
    !module_reset_n && low_q == 16'(MIN_CYC + 1);
  endsequence

  present_low_a: assert property (present_oe_dev && !module_present_n)
    else $error("presence line not low");
  int_sink_a: assert property (module_interrupt_n == !int_oe_dev)
    else $error("interrupt line not open collector");
  sel_pullup_a: assert property (!sel_n_oe_host |-> module_select_n)
    else $error("select line not pulled up");
  rst_pullup_a: assert property (!rst_n_oe_host |-> module_reset_n)
    else $error("reset line not pulled up");
  init_time_a: assert property ($fell(module_interrupt_n) && !done_q |-> cyc_q >= LO)
    else $error("completion interrupt too early");
  init_done_a: assert property (cyc_q == 16'(HI) |-> done_q)
    else $error("completion interrupt missing");
  reset_release_a: assert property (qual_low_s |-> ##[0:3] module_interrupt_n)
    else $error("interrupt held through reset");
  held_quiet_a: assert property ($fell(module_interrupt_n) |-> module_reset_n)
    else $error("interrupt asserted while reset low");
endmodule

// ### verif/test_pluggable_module_sideband_control.sv
// test_pluggable_module_sideband_control: host end and module end joined.
// assumes shortened reset counts; expected values kept in bench variables.
`timescale 1ns/100ps
module test_pluggable_module_sideband_control;
  import psc_pkg::*;
  localparam int unsigned MIN  = 4;
  localparam int unsigned INIT = 20;
  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       reset_req_i = 1'b0;
  logic       select_i = 1'b0;
  logic       low_power_i = 1'b0;
  logic       user_cfg_we_i = 1'b0;
  logic       fault_i = 1'b0;
  logic [7:0] user_cfg_i = 8'h00;
  logic       mgmt_enable_o, data_not_ready_o, low_power_o;
  logic       present_o, status_valid_o, read_flags_o, busy_o;
  logic [7:0] user_cfg_o;
  logic [7:0] exp_cfg = USER_CFG_RESET;
  int         failures = 0;
  int         n_compared = 0;
  int         seed = 35010;
  int         n;

  always #25 clk_i = ~clk_i;
  psc_if pins ();
  psc_module_end #(.RESET_MIN_CYC(MIN), .INIT_CYC(INIT)) psc_module_end_i (.clk_i(clk_i),
    .rstn_i(rstn_i), .pins(pins), .mgmt_enable_o(mgmt_enable_o), .data_not_ready_o(data_not_ready_o),
    .low_power_o(low_power_o), .user_cfg_o(user_cfg_o), .user_cfg_we_i(user_cfg_we_i),
    .user_cfg_i(user_cfg_i), .fault_i(fault_i), .flags_read_i(read_flags_o));
  psc_host_end #(.HOLD_CYC(MIN + 2)) psc_host_end_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .pins(pins), .reset_req_i(reset_req_i), .select_i(select_i), .low_power_i(low_power_i),
    .present_o(present_o), .status_valid_o(status_valid_o), .read_flags_o(read_flags_o),
    .busy_o(busy_o));
  psc_sva #(.MIN_CYC(MIN), .INIT_CYC(INIT)) psc_sva_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .sel_n_oe_host(pins.sel_n_oe_host), .rst_n_oe_host(pins.rst_n_oe_host),
    .present_oe_dev(pins.present_oe_dev), .int_oe_dev(pins.int_oe_dev),
    .module_select_n(pins.module_select_n), .module_reset_n(pins.module_reset_n),
    .module_present_n(pins.module_present_n), .module_interrupt_n(pins.module_interrupt_n));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // polls at the falling edge so outputs have settled
  task automatic wait_int(input int lim, output int cyc);
    cyc = 0;
    while (pins.module_interrupt_n !== 1'b0 && cyc < lim) begin
      @(negedge clk_i);
      cyc++;
    end
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(50 * 3000);
    failures++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk("not_ready", 8'h01, data_not_ready_o);
    chk("status_valid", 8'h00, status_valid_o);
    wait_int(INIT + 20, n);
    chk("powerup_done", 8'h01, 8'(n >= INIT - 4 && n <= INIT + 4));
    chk("not_ready", 8'h00, data_not_ready_o);
    chk("present_n", 8'h00, pins.module_present_n);
    @(negedge clk_i);
    chk("read_flags", 8'h01, read_flags_o);
    chk("present", 8'h01, present_o);
    repeat (4) @(negedge clk_i);
    chk("status_valid", 8'h01, status_valid_o);
    chk("busy", 8'h00, busy_o);
    chk("int_cleared", 8'h01, pins.module_interrupt_n);
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk_i);
      select_i <= s[0];
      low_power_i <= 1'($random(seed));
      repeat (3) @(posedge clk_i);
      user_cfg_i <= 8'($random(seed));
      user_cfg_we_i <= 1'b1;
      @(posedge clk_i);
      user_cfg_we_i <= 1'b0;
      if (s == 1) exp_cfg = user_cfg_i;
      @(negedge clk_i);
      chk("mgmt_enable", 8'(s), mgmt_enable_o);
      chk("user_cfg", exp_cfg, user_cfg_o);
      chk("low_power", 8'(low_power_i), low_power_o);
    end
    @(posedge clk_i);
    reset_req_i <= 1'b1;
    @(posedge clk_i);
    reset_req_i <= 1'b0;
    repeat (MIN + 3) @(negedge clk_i);
    chk("cfg_default", USER_CFG_RESET, user_cfg_o);
    chk("not_ready", 8'h01, data_not_ready_o);
    wait_int(INIT + 20, n);
    chk("reset_done", 8'h01, 8'(n >= INIT - 4 && n <= INIT + 6));
    chk("not_ready", 8'h00, data_not_ready_o);
    repeat (6) @(posedge clk_i);
    fault_i <= 1'b1;
    wait_int(10, n);
    chk("fault_int", 8'h01, 8'(n < 10));
    final_report();
  end
endmodule
